//--- shared/link_pkg.sv
package link_pkg;
  // register offsets from the bus master base
  localparam logic [7:0] GLOB_OFS = 8'h60;
  localparam logic [7:0] CMD_OFS  = 8'h64;
  localparam logic [7:0] STAT_OFS = 8'h68;
  localparam logic [7:0] GPIO_OFS = 8'h6c;
  // field positions
  localparam int COLD_BIT    = 1;
  localparam int PRI_RDY_BIT = 8;
  localparam int SEC_RDY_BIT = 9;
  localparam int CMD_IDX_LSB = 16;
  localparam int CMD_RD_BIT  = 23;
  localparam int CMD_SEC_BIT = 24;
  localparam int BUSY_BIT    = 16;
  localparam int DONE_BIT    = 17;
  localparam int TMO_BIT     = 18;
  localparam int FUNC_BIT    = 19;
  // frame geometry in bit clocks
  localparam logic [7:0] TAG_BITS   = 8'h10;
  localparam logic [7:0] SLOT_BITS  = 8'h14;
  localparam logic [7:0] FRAME_LAST = 8'hff;
  localparam int FRAME_BITS = 256;
  localparam logic [4:0] TAG_LAST  = 5'h0f;
  localparam logic [4:0] SLOT_LAST = 5'h13;
  // slot numbers
  localparam logic [3:0] SLOT_ADDR = 4'h1;
  localparam logic [3:0] SLOT_DATA = 4'h2;
  localparam logic [3:0] SLOT_PCM_L = 4'h3;
  localparam logic [3:0] SLOT_PCM_R = 4'h4;
  localparam logic [3:0] SLOT_MODEM = 4'h5;
  localparam logic [3:0] SLOT_MIC   = 4'h6;
  localparam logic [3:0] SLOT_GPIO  = 4'hc;
  // reset values and counts
  localparam logic [31:0] GLOB_RESET = 32'h0000_0000;
  localparam logic [2:0]  RD_TIMEOUT_FRAMES = 3'h4;
  localparam logic [1:0]  SEC_CODEC_ID = 2'h1;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_SEND = 2'b01,
    ACC_WAIT = 2'b10
  } acc_state_t;

  // slot number of a bit position within the frame
  function automatic logic [3:0] slot_of(input logic [7:0] p);
    logic [7:0] d;
    d = p - TAG_BITS;
    if (p < TAG_BITS) return 4'h0;
    return 4'(d / SLOT_BITS + 8'h01);
  endfunction

  // bit index within its slot, msb first
  function automatic logic [4:0] bit_of(input logic [7:0] p);
    logic [7:0] d;
    d = p - TAG_BITS;
    if (p < TAG_BITS) return p[4:0];
    return 5'(d % SLOT_BITS);
  endfunction
endpackage

//--- rtl/frame_tx.sv
`timescale 1ns/1ps
module frame_tx (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              advance,
  input  wire logic [7:0]        pos_next,
  input  wire logic [15:0]       tag,
  input  wire logic [11:0][19:0] words,
  output logic                   serial_out
);
  import link_pkg::*;

  typedef struct packed {
    logic out;
  } tx_t;

  tx_t s_reg;
  tx_t s_next;
  logic [3:0] sl;
  logic [4:0] b;

  assign sl = slot_of(pos_next);
  assign b  = bit_of(pos_next);

  // next bit goes out on the bit clock rising edge
  always_comb begin
    s_next = s_reg;
    if (advance) begin
      if (sl == 4'h0) begin
        s_next.out = tag[4'hf - b[3:0]];
      end else begin
        s_next.out = tag[4'hf - sl] & words[4'(sl - 4'h1)][5'h13 - b];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign serial_out = s_reg.out;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_tx_on_rise: assert property ($changed(serial_out) |-> $past(advance))
    else $error("serial out changed away from a rising edge");
endmodule

//--- rtl/frame_rx.sv
`timescale 1ns/1ps
module frame_rx (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        advance,
  input  wire logic [7:0]  pos,
  input  wire logic        din,
  output logic [19:0]      word,
  output logic [3:0]       slot,
  output logic             stb
);
  import link_pkg::*;

  typedef struct packed {
    logic [19:0] sh;
    logic [19:0] word;
    logic [3:0]  slot;
    logic        stb;
  } rx_t;

  rx_t s_reg;
  rx_t s_next;
  logic [3:0] sl;
  logic [4:0] b;

  assign sl = slot_of(pos);
  assign b  = bit_of(pos);

  // shift on falling edge, hand over the word at slot end
  always_comb begin
    s_next = s_reg;
    s_next.stb = 1'b0;
    if (advance) begin
      s_next.sh = {s_reg.sh[18:0], din};
      if ((sl == 4'h0 && b == TAG_LAST) || b == SLOT_LAST) begin
        s_next.word = {s_reg.sh[18:0], din};
        s_next.slot = sl;
        s_next.stb  = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign word = s_reg.word;
  assign slot = s_reg.slot;
  assign stb  = s_reg.stb;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_rx_on_fall: assert property (stb |-> $past(advance) && $past(pos) != 8'h00)
    else $error("slot word handed over without a falling edge");
endmodule

//--- rtl/audio_modem_serial_link_controller.sv
// Operation
// - codec reset low until cold bit set
// - link logic held reset with codec reset
// - one cold bit shared by both functions
// - clearing cold bit at 60h resets codec
// - codec ready visible for software probing
// - sync divides bit clock by 256
// - drive on rising, sample on falling
// - one shared output, two input lines
// - each codec addressed individually
// - twelve 20-bit slots after tag
// - 16-bit tag slot marks valid slots
// - invalid slots carry zeros
// - sync high for 16 bit clocks
// - fixed playback, command, modem, gpio slots
// - 16-bit samples only
// - no surround or double rate
// - no second line or handset
// - honour variable rate slot requests
// - modem function shares the link logic
// - gpio status from every frame
`timescale 1ns/1ps
module audio_modem_serial_link_controller (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        link_bit_clock_in,
  input  wire logic        primary_serial_in,
  input  wire logic        secondary_serial_in,
  output logic             shared_serial_out,
  output logic             frame_sync_out,
  output logic             codec_reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_func,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  input  wire logic [15:0] play_left,
  input  wire logic [15:0] play_right,
  input  wire logic        play_valid,
  output logic             play_ack,
  input  wire logic [15:0] modem_out,
  input  wire logic        modem_out_valid,
  output logic             modem_ack,
  input  wire logic [15:0] gpio_out,
  input  wire logic        gpio_out_valid,
  output logic [15:0]      rec_left,
  output logic [15:0]      rec_right,
  output logic [15:0]      mic_sample,
  output logic [15:0]      modem_in,
  output logic             rec_stb
);
  import link_pkg::*;

  typedef struct packed {
    logic              cold;
    logic [2:0]        bs;
    logic [1:0]        pd;
    logic [1:0]        sd;
    logic [7:0]        pos;
    logic              sync;
    logic [15:0]       tag;
    logic [11:0][19:0] tw;
    acc_state_t        acc;
    logic              busy;
    logic              done;
    logic              tmo;
    logic [2:0]        tmo_cnt;
    logic              c_rd;
    logic              c_sec;
    logic              c_func;
    logic [6:0]        c_idx;
    logic [15:0]       c_wdata;
    logic [15:0]       c_rdata;
    logic [1:0][15:0]  rtag;
    logic [1:0][6:0]   saddr;
    logic [9:0]        preq;
    logic [15:0]       rec_l;
    logic [15:0]       rec_r;
    logic [15:0]       mic;
    logic [15:0]       mdm;
    logic [15:0]       gpio;
    logic              rec_stb;
    logic              play_ack;
    logic              modem_ack;
    logic [31:0]       rdata;
  } st_t;

  st_t s_reg;
  st_t s_next;
  logic rise;
  logic fall;
  logic frame_start;
  logic [1:0][19:0] rx_w;
  logic [1:0][3:0]  rx_s;
  logic [1:0]       rx_v;

  // bit clock edges seen in the mclk domain
  assign rise = s_reg.bs[1] & ~s_reg.bs[2];
  assign fall = ~s_reg.bs[1] & s_reg.bs[2];
  assign frame_start = rise && s_reg.pos == FRAME_LAST;

  // one serializer on the shared line
  frame_tx u_tx (
    .mclk       (mclk),
    .rstn       (s_reg.cold),
    .advance    (rise),
    .pos_next   (s_next.pos),
    .tag        (s_next.tag),
    .words      (s_next.tw),
    .serial_out (shared_serial_out)
  );

  // a receiver per input line, no contention between codecs
  frame_rx u_rx_pri (
    .mclk    (mclk),
    .rstn    (s_reg.cold),
    .advance (fall),
    .pos     (s_reg.pos),
    .din     (s_reg.pd[1]),
    .word    (rx_w[0]),
    .slot    (rx_s[0]),
    .stb     (rx_v[0])
  );

  frame_rx u_rx_sec (
    .mclk    (mclk),
    .rstn    (s_reg.cold),
    .advance (fall),
    .pos     (s_reg.pos),
    .din     (s_reg.sd[1]),
    .word    (rx_w[1]),
    .slot    (rx_s[1]),
    .stb     (rx_v[1])
  );

  // whole next state of the controller
  always_comb begin
    s_next = s_reg;
    s_next.bs = {s_reg.bs[1:0], link_bit_clock_in};
    s_next.pd = {s_reg.pd[0], primary_serial_in};
    s_next.sd = {s_reg.sd[0], secondary_serial_in};
    s_next.rec_stb   = 1'b0;
    s_next.play_ack  = 1'b0;
    s_next.modem_ack = 1'b0;
    // register writes, either function reaches the same storage
    if (reg_wr) begin
      if (reg_addr == GLOB_OFS) begin
        s_next.cold = reg_wdata[COLD_BIT];
      end else if (reg_addr == CMD_OFS) begin
        if (!s_reg.busy && s_reg.cold) begin
          s_next.c_wdata = reg_wdata[15:0];
          s_next.c_idx   = reg_wdata[CMD_IDX_LSB +: 7];
          s_next.c_rd    = reg_wdata[CMD_RD_BIT];
          s_next.c_sec   = reg_wdata[CMD_SEC_BIT];
          s_next.c_func  = reg_func;
          s_next.acc     = ACC_SEND;
          s_next.busy    = 1'b1;
          s_next.done    = 1'b0;
          s_next.tmo     = 1'b0;
        end
      end else if (reg_addr == STAT_OFS) begin
        if (reg_wdata[DONE_BIT]) s_next.done = 1'b0;
      end
    end
    // register reads, answered one cycle later
    if (reg_rd) begin
      s_next.rdata = 32'h0000_0000;
      if (reg_addr == GLOB_OFS) begin
        s_next.rdata[COLD_BIT]    = s_reg.cold;
        s_next.rdata[PRI_RDY_BIT] = s_reg.rtag[0][15];
        s_next.rdata[SEC_RDY_BIT] = s_reg.rtag[1][15];
      end else if (reg_addr == CMD_OFS) begin
        s_next.rdata = {7'h00, s_reg.c_sec, s_reg.c_rd, s_reg.c_idx, s_reg.c_wdata};
      end else if (reg_addr == STAT_OFS) begin
        s_next.rdata = {12'h000, s_reg.c_func, s_reg.tmo, s_reg.done, s_reg.busy, s_reg.c_rdata};
      end else if (reg_addr == GPIO_OFS) begin
        s_next.rdata = {16'h0000, s_reg.gpio};
      end
    end
    // frame counter and sync
    if (rise) begin
      s_next.pos  = s_reg.pos + 8'h01;
      s_next.sync = s_next.pos < TAG_BITS;
    end
    // build the outgoing frame at its first bit
    if (frame_start) begin
      s_next.tag = 16'h0000;
      s_next.tw  = '0;
      if (s_reg.acc == ACC_SEND) begin
        s_next.tag[15 - SLOT_ADDR] = 1'b1;
        s_next.tag[15 - SLOT_DATA] = !s_reg.c_rd;
        s_next.tag[1:0] = s_reg.c_sec ? SEC_CODEC_ID : 2'h0;
        s_next.tw[SLOT_ADDR - 1] = {s_reg.c_rd, s_reg.c_idx, 12'h000};
        s_next.tw[SLOT_DATA - 1] = s_reg.c_rd ? 20'h00000 : {s_reg.c_wdata, 4'h0};
        s_next.acc = ACC_WAIT;
        s_next.tmo_cnt = 3'h0;
      end else if (s_reg.acc == ACC_WAIT) begin
        if (!s_reg.c_rd) begin
          s_next.acc  = ACC_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end else if (s_reg.tmo_cnt == RD_TIMEOUT_FRAMES) begin
          s_next.acc  = ACC_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          s_next.tmo  = 1'b1;
        end else begin
          s_next.tmo_cnt = s_reg.tmo_cnt + 3'h1;
        end
      end
      // pcm and modem only when the codec asks for them
      if (play_valid && !s_reg.preq[9] && !s_reg.preq[8]) begin
        s_next.tag[15 - SLOT_PCM_L] = 1'b1;
        s_next.tag[15 - SLOT_PCM_R] = 1'b1;
        s_next.tw[SLOT_PCM_L - 1] = {play_left, 4'h0};
        s_next.tw[SLOT_PCM_R - 1] = {play_right, 4'h0};
        s_next.play_ack = 1'b1;
      end
      if (modem_out_valid && !s_reg.preq[7]) begin
        s_next.tag[15 - SLOT_MODEM] = 1'b1;
        s_next.tw[SLOT_MODEM - 1] = {modem_out, 4'h0};
        s_next.modem_ack = 1'b1;
      end
      if (gpio_out_valid) begin
        s_next.tag[15 - SLOT_GPIO] = 1'b1;
        s_next.tw[SLOT_GPIO - 1] = {gpio_out, 4'h0};
      end
      s_next.tag[15] = |s_next.tag[14:0];
    end
    // incoming slots from both lines
    for (int i = 0; i < 2; i++) begin
      if (rx_v[i]) begin
        if (rx_s[i] == 4'h0) begin
          s_next.rtag[i] = rx_w[i][15:0];
        end else if (s_reg.rtag[i][4'hf - rx_s[i]]) begin
          case (rx_s[i])
            SLOT_ADDR: begin
              s_next.saddr[i] = rx_w[i][18:12];
              if (i == 0) s_next.preq = rx_w[i][11:2];
            end
            SLOT_DATA: begin
              if (s_reg.acc == ACC_WAIT && s_reg.c_rd && s_reg.c_sec == 1'(i)
                  && s_reg.saddr[i] == s_reg.c_idx) begin
                s_next.c_rdata = rx_w[i][19:4];
                s_next.acc  = ACC_IDLE;
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
              end
            end
            SLOT_PCM_L: s_next.rec_l = rx_w[i][19:4];
            SLOT_PCM_R: begin
              s_next.rec_r = rx_w[i][19:4];
              s_next.rec_stb = 1'b1;
            end
            SLOT_MODEM: s_next.mdm = rx_w[i][19:4];
            SLOT_MIC: s_next.mic = rx_w[i][19:4];
            SLOT_GPIO: s_next.gpio = rx_w[i][19:4];
            default: ;
          endcase
        end
      end
    end
    // link held in reset together with the codec
    if (!s_reg.cold) begin
      s_next.pos  = FRAME_LAST;
      s_next.sync = 1'b0;
      s_next.tag  = 16'h0000;
      s_next.tw   = '0;
      s_next.rtag = '0;
      s_next.acc  = ACC_IDLE;
      s_next.busy = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_reg      <= '0;
      s_reg.cold <= GLOB_RESET[COLD_BIT];
      s_reg.pos  <= FRAME_LAST;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from state
  assign frame_sync_out = s_reg.sync;
  assign codec_reset_n  = s_reg.cold;
  assign reg_rdata      = s_reg.rdata;
  assign play_ack       = s_reg.play_ack;
  assign modem_ack      = s_reg.modem_ack;
  assign rec_left       = s_reg.rec_l;
  assign rec_right      = s_reg.rec_r;
  assign mic_sample     = s_reg.mic;
  assign modem_in       = s_reg.mdm;
  assign rec_stb        = s_reg.rec_stb;

  // helper counters for the checks below
  logic [8:0] frame_len;
  logic [4:0] sync_len;
  always_ff @(posedge mclk) begin
    if (!rstn || !s_reg.cold) begin
      frame_len <= 9'h000;
      sync_len  <= 5'h00;
    end else if (rise) begin
      frame_len <= frame_start ? 9'h001 : frame_len + 9'h001;
      sync_len  <= frame_start ? 5'h00 : (frame_sync_out ? sync_len + 5'h01 : sync_len);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_reset_held: assert property (!s_reg.cold |-> !codec_reset_n)
    else $error("codec reset released without cold bit");
  a_link_reset: assert property (!s_reg.cold |=> !frame_sync_out && s_reg.pos == FRAME_LAST)
    else $error("link ran while codec held in reset");
  a_shared_cold: assert property (reg_wr && reg_addr == GLOB_OFS && reg_wdata[COLD_BIT]
    |=> codec_reset_n)
    else $error("cold bit write from a function ignored");
  a_clear_resets: assert property ($fell(s_reg.cold) |-> !codec_reset_n ##1 !frame_sync_out)
    else $error("clearing cold bit did not reset codec");
  a_frame_len: assert property (frame_start && frame_len != 9'h000 |-> frame_len == 9'(FRAME_BITS))
    else $error("frame not 256 bit clocks");
  a_sync_width: assert property ($fell(frame_sync_out) && codec_reset_n |-> sync_len == 5'h10)
    else $error("sync not high for 16 bit clocks");
  a_invalid_zero: assert property (slot_of(s_reg.pos) != 4'h0
    && !s_reg.tag[4'hf - slot_of(s_reg.pos)] |-> !shared_serial_out)
    else $error("invalid slot not zero");
  a_cmd_tagged: assert property (frame_start && s_reg.acc == ACC_SEND |=> s_reg.tag[14]
    && s_reg.tag[13] == !s_reg.c_rd)
    else $error("command slot not tagged");
  a_sample_16: assert property (s_reg.tw[2][3:0] == 4'h0 && s_reg.tw[3][3:0] == 4'h0)
    else $error("pcm sample wider than 16 bits");
  a_gpio_capture: assert property (rx_v[0] && rx_s[0] == SLOT_GPIO && s_reg.rtag[0][3]
    |=> s_reg.gpio == $past(rx_w[0][19:4]))
    else $error("gpio status not captured");

  c_frame: cover property (frame_start ##1 frame_sync_out);
  c_read_done: cover property (s_reg.busy && s_reg.c_rd ##1 s_reg.done && !s_reg.tmo);
  c_write_done: cover property (s_reg.busy && !s_reg.c_rd ##1 s_reg.done);
  c_play: cover property (play_ack);
endmodule

//--- bench/codec_model.sv
`timescale 1ns/1ps
module codec_model #(
  parameter bit          IS_PRI = 1'b1,
  parameter logic [1:0]  ID     = 2'h0,
  parameter logic [15:0] BASE   = 16'h1230,
  parameter logic [15:0] CAPS   = 16'h0d40  // arbitrary type code
) (
  output logic         bclk_out,
  input  wire logic    bclk_in,
  input  wire logic    rst_n,
  input  wire logic    sync,
  input  wire logic    sdo,
  input  wire logic    present,
  input  wire logic    hold_pcm,
  output logic         sdi,
  output logic [255:0] last_frame,
  output int           flen,
  output int           hlen
);
  logic [15:0]  regs [128];
  logic [255:0] rxv;
  logic [255:0] txv;
  logic [6:0]   ridx;
  logic         rsp;
  logic         sync_q;
  logic         synced;
  int           cnt;
  int           hcnt;

  // power-up state, primary makes the free-running bit clock
  initial begin
    bclk_out = 1'b0;
    sdi = 1'b0;
    rsp = 1'b0;
    sync_q = 1'b0;
    synced = 1'b0;
    cnt = 0;
    hcnt = 0;
    flen = 0;
    hlen = 0;
    rxv = '0;
    txv = '0;
    ridx = '0;
    last_frame = '0;
    foreach (regs[i]) regs[i] = 16'h0000;
    regs[0] = CAPS;
    if (IS_PRI) forever #40.690 bclk_out = ~bclk_out;
  end

  // mark a slot valid in the tag and fill it msb first
  task automatic put(input int s, input logic [15:0] v);
    txv[255 - s] = 1'b1;
    txv[239 - 20 * (s - 1) -: 20] = {v, 4'h0};
  endtask

  // sample sync and data on the falling edge, secondary on the shared clock
  always @(negedge bclk_in) begin
    if (sync && !sync_q) begin
      flen = cnt + 1;
      hlen = hcnt;
      cnt = 0;
      hcnt = 0;
      synced = rst_n;
    end else begin
      cnt = cnt + 1;
    end
    if (sync) hcnt = hcnt + 1;
    sync_q = sync;
    rxv = {rxv[254:0], sdo};
    if (cnt == 255) last_frame = rxv;
    // only commands tagged for this codec id reach its own registers
    if (cnt == 255 && present && rst_n && rxv[255] && rxv[254] && rxv[241:240] == ID) begin
      if (rxv[239]) begin
        rsp = 1'b1;
        ridx = rxv[238:232];
      end else if (rxv[253]) begin
        regs[rxv[238:232]] = rxv[219:204];
      end
    end
  end

  // drive on the rising edge, frame rebuilt at each frame start
  always @(posedge bclk_in) begin
    if (((cnt + 1) & 255) == 0) begin
      txv = '0;
      txv[255] = 1'b1;
      if (IS_PRI) begin
        txv[254] = 1'b1;  // slot 1 always carries the rate requests
        put(3, BASE + 16'h1);
        put(4, BASE + 16'h2);
        put(5, BASE + 16'h3);
        put(6, BASE + 16'h4);
        put(12, BASE + 16'h5);
      end
      if (rsp) begin
        put(1, {1'b0, ridx, 8'h00});
        put(2, regs[ridx]);
      end
      txv[231:230] = {2{hold_pcm}};
      rsp = 1'b0;
    end
    // invalid slots and an absent codec give zeros
    if (present && rst_n && synced) sdi <= txv[255 - ((cnt + 1) & 255)];
    else sdi <= 1'b0;
  end
endmodule

//--- bench/tb_audio_modem_serial_link_controller.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value at %0t: %s", $time, m); end end
module tb_audio_modem_serial_link_controller;
  import link_pkg::*;
  wire         link_bit_clock_in;
  logic        mclk, rstn, primary_serial_in, secondary_serial_in, shared_serial_out, frame_sync_out, codec_reset_n;
  logic [7:0]  reg_addr;
  logic        reg_func, reg_wr, reg_rd, play_valid, play_ack, modem_out_valid, modem_ack, gpio_out_valid, rec_stb;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] play_left, play_right, modem_out, gpio_out, rec_left, rec_right, mic_sample, modem_in;
  logic        sec_present, hold_pcm;
  logic [255:0] frame0;
  int          flen, hlen, k, n_mismatch, tests_run;

  audio_modem_serial_link_controller i_dut (.mclk, .rstn, .link_bit_clock_in, .primary_serial_in,
    .secondary_serial_in, .shared_serial_out, .frame_sync_out, .codec_reset_n, .reg_addr, .reg_func, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .play_left, .play_right, .play_valid, .play_ack, .modem_out,
    .modem_out_valid, .modem_ack, .gpio_out, .gpio_out_valid, .rec_left, .rec_right, .mic_sample, .modem_in,
    .rec_stb);
  codec_model i_pri (.bclk_out(link_bit_clock_in), .bclk_in(link_bit_clock_in), .rst_n(codec_reset_n),
    .sync(frame_sync_out), .sdo(shared_serial_out), .present(1'b1), .hold_pcm, .sdi(primary_serial_in),
    .last_frame(frame0), .flen, .hlen);
  codec_model #(.IS_PRI(1'b0), .ID(SEC_CODEC_ID), .BASE(16'h0000)) i_sec (.bclk_out(),
    .bclk_in(link_bit_clock_in), .rst_n(codec_reset_n), .sync(frame_sync_out), .sdo(shared_serial_out),
    .present(sec_present), .hold_pcm(1'b0), .sdi(secondary_serial_in), .last_frame(), .flen(), .hlen());

  // system clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  // issue a codec command, poll status until idle with done or timeout
  task automatic cmd(input logic sec, input logic rdn, input logic [6:0] idx, input logic [15:0] v,
                     output logic [31:0] st);
    int n;
    wr(CMD_OFS, {7'h00, sec, rdn, idx, v});
    st = 32'h0001_0000;
    for (n = 0; n < 20000 && (st[BUSY_BIT] || !(st[DONE_BIT] || st[TMO_BIT])); n++) rd(STAT_OFS, st);
    wr(STAT_OFS, 32'h0002_0000);
  endtask

  task automatic frames(input int n);
    repeat (n * 4170) @(negedge mclk);
  endtask

  task automatic give_verdict;
    $display("counts: %0d compared, %0d wrong", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard
  initial begin
    #500_000;
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    give_verdict;
  end

  // main sequence
  initial begin
    {rstn, reg_addr, reg_func, reg_wr, reg_rd, reg_wdata, sec_present, hold_pcm} = '0;
    {play_valid, modem_out_valid, gpio_out_valid} = 3'b000;
    play_left = 16'h1357;
    play_right = 16'h2468;
    modem_out = 16'h9abc;
    gpio_out = 16'h00f1;
    n_mismatch = 0;
    tests_run = 0;
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    repeat (1000) @(negedge mclk);
    `CHK(codec_reset_n, 1'b0, "codec reset released early")
    `CHK(frame_sync_out, 1'b0, "sync before cold reset")
    rd(GLOB_OFS, d);
    `CHK(d, GLOB_RESET, "global reset value")
    rd(8'h70, d);
    `CHK(d, 32'h0, "unmapped read")
    $display("test reset done");
    reg_func = 1'b1;
    wr(GLOB_OFS, 32'h0000_0002);
    reg_func = 1'b0;
    frames(2);
    rd(GLOB_OFS, d);
    `CHK(d[COLD_BIT], 1'b1, "cold bit")
    `CHK(codec_reset_n, 1'b1, "codec reset held")
    `CHK(d[PRI_RDY_BIT], 1'b1, "primary ready")
    `CHK(d[SEC_RDY_BIT], 1'b0, "absent secondary ready")
    `CHK(flen, FRAME_BITS, "frame length")
    `CHK(hlen, 16, "sync width")
    $display("test link start done");
    {play_valid, modem_out_valid, gpio_out_valid} = 3'b111;
    for (k = 0; k < 10000 && play_ack !== 1'b1; k++) @(negedge mclk);
    `CHK(play_ack, 1'b1, "playback ack")
    `CHK(modem_ack, 1'b1, "modem ack")
    for (k = 0; k < 5000 && rec_stb !== 1'b1; k++) @(negedge mclk);
    `CHK(rec_stb, 1'b1, "record strobe")
    frames(1);
    `CHK(frame0[255:240], 16'h9c08, "output tag")
    `CHK(frame0[199:180], {play_left, 4'h0}, "left slot")
    `CHK(frame0[179:160], {play_right, 4'h0}, "right slot")
    `CHK(frame0[159:140], {modem_out, 4'h0}, "modem slot")
    `CHK(frame0[19:0], {gpio_out, 4'h0}, "gpio slot")
    `CHK(frame0[139:20], 120'h0, "unused slots")
    `CHK(frame0[239:200], 40'h0, "idle command slots")
    `CHK(rec_left, 16'h1231, "record left")
    `CHK(rec_right, 16'h1232, "record right")
    `CHK(modem_in, 16'h1233, "modem in")
    `CHK(mic_sample, 16'h1234, "mic")
    rd(GPIO_OFS, d);
    `CHK(d[15:0], 16'h1235, "gpio status")
    $display("test streams done");
    hold_pcm = 1'b1;
    frames(3);
    `CHK(frame0[255:240], 16'h8408, "tag without request")
    `CHK(frame0[199:160], 40'h0, "pcm without request")
    hold_pcm = 1'b0;
    $display("test rate request done");
    reg_func = 1'b1;
    cmd(1'b0, 1'b0, 7'h02, 16'h5a5a, d);
    `CHK(i_pri.regs[2], 16'h5a5a, "primary write")
    cmd(1'b0, 1'b1, 7'h00, 16'h0000, d);
    `CHK(d[15:0], 16'h0d40, "primary type read")
    `CHK(d[FUNC_BIT], 1'b1, "issuing function")
    reg_func = 1'b0;
    cmd(1'b1, 1'b1, 7'h00, 16'h0000, d);
    `CHK(d[TMO_BIT], 1'b1, "absent codec timeout")
    $display("test primary access done");
    sec_present = 1'b1;
    cmd(1'b1, 1'b0, 7'h03, 16'hc3c3, d);
    `CHK(i_sec.regs[3], 16'hc3c3, "secondary write")
    rd(GLOB_OFS, d);
    `CHK(d[SEC_RDY_BIT], 1'b1, "secondary ready")
    `CHK(i_pri.regs[3], 16'h0000, "primary untouched")
    cmd(1'b1, 1'b1, 7'h03, 16'h0000, d);
    `CHK(d[15:0], 16'hc3c3, "secondary read")
    `CHK(d[TMO_BIT], 1'b0, "secondary timeout")
    $display("test secondary access done");
    wr(GLOB_OFS, 32'h0);
    repeat (2) @(negedge mclk);
    `CHK(codec_reset_n, 1'b0, "warm codec reset")
    repeat (1000) @(negedge mclk);
    `CHK(frame_sync_out, 1'b0, "sync during reset")
    $display("test reset clear done");
    give_verdict;
  end
endmodule
